// ==== common/axm_pkg.sv ====
// Package for the axis motion command controller: register map, field layouts,
// command indices, codes and timing constants.
// Assumes a 250 MHz APB clock and one axis behind a fieldbus drive.
package axm_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VEL = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_TRQ = 8'h0C;
  localparam logic [7:0] ADDR_SLOPE = 8'h10;
  localparam logic [7:0] ADDR_HALT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_ERR = 8'h1C;
  localparam logic [7:0] ADDR_MON = 8'h20;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Commands and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_VEL = 2'h0;
  localparam logic [1:0] CMD_TRQ = 2'h1;
  localparam logic [1:0] CMD_HLT = 2'h2;
  localparam logic [1:0] CMD_EST = 2'h3;
  localparam int CMD_CLR = 4;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_REV = 2'h2;
  localparam logic [1:0] DIR_KEEP = 2'h3;
  localparam logic CLR_AXIS = 1'b0;
  localparam logic CLR_COMMON = 1'b1;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ESTOP_LOCK = 8'h01;
  localparam logic [7:0] ERR_NOT_READY = 8'h02;
  localparam logic [7:0] ERR_BAD_DIR = 8'h03;
  localparam logic [7:0] ERR_DRIVE_FAULT = 8'h04;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_NS = 1_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {ST_IDLE, ST_VEL, ST_TRQ, ST_HALT, ST_ESTOP} axm_state_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic clr_type;
    logic live;
    logic buffered;
    logic [1:0] trq_dir;
    logic [1:0] vel_dir;
    logic [4:0] exec;
  } axm_ctrl_t;

  typedef struct packed {
    logic [2:0] r3;
    logic [4:0] done;
    logic [3:0] r2;
    logic [3:0] act;
    logic [2:0] r1;
    logic [4:0] busy;
    logic [1:0] r0;
    logic common_err;
    logic axis_err;
    logic in_op;
    logic err_warn;
    logic servo_on;
    logic connected;
  } axm_stat_t;

  typedef struct packed {
    logic [6:0] r1;
    logic warn;
    logic [7:0] drv_code;
    logic [7:0] errnum;
    logic [2:0] r0;
    logic [4:0] err;
  } axm_errs_t;

  typedef struct packed {
    logic link_ok;
    logic servo_on;
    logic warn;
    logic [7:0] err_code;
  } axm_drv_in_t;

  typedef struct packed {
    logic trq_mode;
    logic clr_axis;
    logic clr_common;
    logic [15:0] spd_cmd;
    logic [15:0] trq_cmd;
  } axm_drv_out_t;
endpackage

// ==== rtl/axm_ctrl.sv ====
// Axis motion command controller: APB registers, command handshakes,
// speed and torque ramps towards the drive.
// Assumes drive feedback synchronous to pclk and one axis.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module axm_ctrl #(
  parameter int unsigned TICK_CYCLES = axm_pkg::TICK_CYC,
  parameter logic [15:0] ESTOP_STEP = 16'h0100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire axm_pkg::axm_drv_in_t drv_in,
  output axm_pkg::axm_drv_out_t drv_out
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  axm_pkg::axm_ctrl_t ctrl;
  axm_pkg::axm_state_t state, next_state;
  axm_pkg::axm_stat_t stat;
  axm_pkg::axm_errs_t errs;
  logic [14:0] vel_reg, trq_reg, run_vel, run_trq;
  logic [15:0] acc_reg, slope_reg, halt_dec, halt_jerk, run_acc, run_slope, dec_now;
  logic [1:0] run_vdir, run_tdir, sel, pend_idx;
  logic [4:0] exec_q, rise, busy, done, err;
  logic [3:0] act;
  logic [7:0] errnum, code;
  logic pend_v, axis_err, common_err, keep_neg, ready, flt, cur_busy, sel_v;
  logic accept, refuse, defer, vneg, tneg, at_vel, at_trq, trq_step, tick;
  logic clr_axis, clr_common, hit, ro;
  logic signed [15:0] spd, trq, vtgt, ttgt;
  logic [14:0] eff_vel, eff_trq;
  logic [15:0] eff_acc, eff_slope;
  logic [1:0] eff_vdir, eff_tdir;
  logic [27:0] frac, frac_sum;
  logic [31:0] tick_cnt, rd_mux;

  function automatic logic signed [15:0] axm_ramp(input logic signed [15:0] cur,
      input logic signed [15:0] tgt, input logic [15:0] step);
    logic signed [16:0] d;
    logic signed [16:0] s;
    d = 17'(tgt) - 17'(cur);
    s = $signed({1'b0, step});
    if (d > s) begin
      axm_ramp = 16'(17'(cur) + s);
    end else if (d < -s) begin
      axm_ramp = 16'(17'(cur) - s);
    end else begin
      axm_ramp = tgt;
    end
  endfunction

  // ----------------------------------------------------------------
  // APB slave: no wait states, read data captured in setup
  // ----------------------------------------------------------------
  assign pready = penable;
  assign stat = '{done: done, act: act, busy: busy, common_err: common_err,
      axis_err: axis_err, in_op: state != axm_pkg::ST_IDLE,
      err_warn: axis_err | common_err | drv_in.warn | (drv_in.err_code != 8'h00),
      servo_on: drv_in.servo_on,
      connected: drv_in.link_ok,
      default: '0};
  assign errs = '{warn: drv_in.warn, drv_code: drv_in.err_code, errnum: errnum, err: err,
      default: '0};

  always_comb begin
    hit = 1'b1;
    ro = 1'b0;
    rd_mux = 32'h0000_0000;
    case (paddr)
      axm_pkg::ADDR_CTRL: rd_mux = ctrl;
      axm_pkg::ADDR_VEL: rd_mux = {17'h00000, vel_reg};
      axm_pkg::ADDR_ACC: rd_mux = {16'h0000, acc_reg};
      axm_pkg::ADDR_TRQ: rd_mux = {17'h00000, trq_reg};
      axm_pkg::ADDR_SLOPE: rd_mux = {16'h0000, slope_reg};
      axm_pkg::ADDR_HALT: rd_mux = {halt_jerk, halt_dec};
      axm_pkg::ADDR_STAT: begin
        rd_mux = stat;
        ro = 1'b1;
      end
      axm_pkg::ADDR_ERR: begin
        rd_mux = errs;
        ro = 1'b1;
      end
      axm_pkg::ADDR_MON: begin
        rd_mux = {trq, spd};
        ro = 1'b1;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
      pslverr <= !hit || (pwrite && ro);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= axm_pkg::RST_CTRL;
      vel_reg <= axm_pkg::RST_WORD[14:0];
      trq_reg <= axm_pkg::RST_WORD[14:0];
      acc_reg <= axm_pkg::RST_WORD;
      slope_reg <= axm_pkg::RST_WORD;
      halt_dec <= axm_pkg::RST_WORD;
      halt_jerk <= axm_pkg::RST_WORD;
    end else if (psel && penable && pwrite && !pslverr) begin
      case (paddr)
        axm_pkg::ADDR_CTRL: ctrl <= {20'h00000, pwdata[11:0]};
        axm_pkg::ADDR_VEL: vel_reg <= pwdata[14:0];
        axm_pkg::ADDR_ACC: acc_reg <= pwdata[15:0];
        axm_pkg::ADDR_TRQ: trq_reg <= pwdata[14:0];
        axm_pkg::ADDR_SLOPE: slope_reg <= pwdata[15:0];
        axm_pkg::ADDR_HALT: begin
          halt_dec <= pwdata[15:0];
          halt_jerk <= pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command arbitration
  // ----------------------------------------------------------------
  assign rise = ctrl.exec & ~exec_q;
  assign ready = drv_in.link_ok & drv_in.servo_on;
  assign cur_busy = |(busy[3:0] & act);
  assign flt = (state != axm_pkg::ST_IDLE) && !(ready && drv_in.err_code == 8'h00);

  // Emergency stop wins, then halt, torque, velocity
  always_comb begin
    sel_v = 1'b1;
    sel = axm_pkg::CMD_VEL;
    if (rise[axm_pkg::CMD_EST]) begin
      sel = axm_pkg::CMD_EST;
    end else if (rise[axm_pkg::CMD_HLT]) begin
      sel = axm_pkg::CMD_HLT;
    end else if (rise[axm_pkg::CMD_TRQ]) begin
      sel = axm_pkg::CMD_TRQ;
    end else if (rise[axm_pkg::CMD_VEL]) begin
      sel = axm_pkg::CMD_VEL;
    end else if (pend_v && !cur_busy) begin
      sel = pend_idx;
    end else begin
      sel_v = 1'b0;
    end
  end

  always_comb begin
    code = axm_pkg::ERR_NONE;
    if (state == axm_pkg::ST_ESTOP) begin
      code = axm_pkg::ERR_ESTOP_LOCK;
    end else if (!ready) begin
      code = axm_pkg::ERR_NOT_READY;
    end else if (sel == axm_pkg::CMD_VEL && ctrl.vel_dir == 2'h0) begin
      code = axm_pkg::ERR_BAD_DIR;
    end else if (sel == axm_pkg::CMD_TRQ && ctrl.trq_dir != axm_pkg::DIR_FWD
        && ctrl.trq_dir != axm_pkg::DIR_REV) begin
      code = axm_pkg::ERR_BAD_DIR;
    end
  end

  // Emergency stop never queues behind a move, and nothing queues during one
  assign defer = sel_v && rise[sel] && ctrl.buffered && cur_busy
      && sel != axm_pkg::CMD_EST && state != axm_pkg::ST_ESTOP;
  assign accept = sel_v && !defer && code == axm_pkg::ERR_NONE;
  assign refuse = sel_v && !defer && code != axm_pkg::ERR_NONE;

  always_comb begin
    case (sel)
      axm_pkg::CMD_TRQ: next_state = axm_pkg::ST_TRQ;
      axm_pkg::CMD_HLT: next_state = axm_pkg::ST_HALT;
      axm_pkg::CMD_EST: next_state = axm_pkg::ST_ESTOP;
      default: next_state = axm_pkg::ST_VEL;
    endcase
  end

  // ----------------------------------------------------------------
  // Handshakes and axis state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_q <= 5'h00;
      state <= axm_pkg::ST_IDLE;
      busy <= 5'h00;
      act <= 4'h0;
      done <= 5'h00;
      err <= 5'h00;
      errnum <= axm_pkg::ERR_NONE;
      pend_v <= 1'b0;
      pend_idx <= 2'h0;
    end else begin
      exec_q <= ctrl.exec;
      done <= done & ctrl.exec;
      err <= err & ctrl.exec;
      busy[axm_pkg::CMD_CLR] <= rise[axm_pkg::CMD_CLR] & !busy[axm_pkg::CMD_CLR];
      if (busy[axm_pkg::CMD_CLR]) begin
        done[axm_pkg::CMD_CLR] <= 1'b1;
      end
      case (state)
        axm_pkg::ST_VEL: if (busy[axm_pkg::CMD_VEL] && act[axm_pkg::CMD_VEL] && at_vel) begin
          done[axm_pkg::CMD_VEL] <= 1'b1;
          busy[axm_pkg::CMD_VEL] <= 1'b0;
        end
        axm_pkg::ST_TRQ: if (busy[axm_pkg::CMD_TRQ] && act[axm_pkg::CMD_TRQ] && at_trq) begin
          done[axm_pkg::CMD_TRQ] <= 1'b1;
          busy[axm_pkg::CMD_TRQ] <= 1'b0;
        end
        axm_pkg::ST_HALT: if (spd == 16'sh0000) begin
          done[axm_pkg::CMD_HLT] <= 1'b1;
          busy[axm_pkg::CMD_HLT] <= 1'b0;
          act <= 4'h0;
          state <= axm_pkg::ST_IDLE;
        end
        axm_pkg::ST_ESTOP: if (busy[axm_pkg::CMD_EST] && spd == 16'sh0000) begin
          done[axm_pkg::CMD_EST] <= 1'b1;
          busy[axm_pkg::CMD_EST] <= 1'b0;
        end else if (!busy[axm_pkg::CMD_EST] && !ctrl.exec[axm_pkg::CMD_EST]) begin
          state <= axm_pkg::ST_IDLE;
        end
        default: ;
      endcase
      if (flt) begin
        err[3:0] <= (err[3:0] & ctrl.exec[3:0]) | act;
        busy[3:0] <= busy[3:0] & ~act;
        act <= 4'h0;
        errnum <= axm_pkg::ERR_DRIVE_FAULT;
        state <= axm_pkg::ST_IDLE;
      end
      if (defer) begin
        if (pend_v && pend_idx != sel) begin
          busy[pend_idx] <= 1'b0;
        end
        pend_v <= 1'b1;
        pend_idx <= sel;
        busy[sel] <= 1'b1;
        done[sel] <= 1'b0;
        err[sel] <= 1'b0;
      end
      if (accept) begin
        state <= next_state;
        act <= 4'(4'h1 << sel);
        busy[3:0] <= (busy[3:0] & ~act) | 4'(4'h1 << sel);
        done[sel] <= 1'b0;
        err[sel] <= 1'b0;
      end
      if (refuse) begin
        err[sel] <= 1'b1;
        busy[sel] <= 1'b0;
        errnum <= code;
      end
      if ((accept || refuse) && pend_v && (!rise[sel] || pend_idx == sel)) begin
        pend_v <= 1'b0;
      end
    end
  end

  // Fault clear: error latches clear, but a new fault in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_err <= 1'b0;
      common_err <= 1'b0;
      clr_axis <= 1'b0;
      clr_common <= 1'b0;
    end else begin
      clr_axis <= busy[axm_pkg::CMD_CLR] && ctrl.clr_type == axm_pkg::CLR_AXIS;
      clr_common <= busy[axm_pkg::CMD_CLR] && ctrl.clr_type == axm_pkg::CLR_COMMON;
      if (busy[axm_pkg::CMD_CLR] && ctrl.clr_type == axm_pkg::CLR_AXIS) begin
        axis_err <= 1'b0;
      end
      if (busy[axm_pkg::CMD_CLR] && ctrl.clr_type == axm_pkg::CLR_COMMON) begin
        common_err <= 1'b0;
      end
      if (flt) begin
        axis_err <= 1'b1;
      end
      if (psel && penable && pslverr) begin
        common_err <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Setpoint latching
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_vel <= axm_pkg::RST_WORD[14:0];
      run_trq <= axm_pkg::RST_WORD[14:0];
      run_acc <= axm_pkg::RST_WORD;
      run_slope <= axm_pkg::RST_WORD;
      run_vdir <= axm_pkg::DIR_FWD;
      run_tdir <= axm_pkg::DIR_FWD;
      keep_neg <= 1'b0;
    end else if (accept) begin
      run_vel <= vel_reg;
      run_trq <= trq_reg;
      run_acc <= acc_reg;
      run_slope <= slope_reg;
      run_vdir <= ctrl.vel_dir;
      run_tdir <= ctrl.trq_dir;
      keep_neg <= spd[15];
    end
  end

  // Live mode follows the registers; otherwise values frozen at start
  assign eff_vel = ctrl.live ? vel_reg : run_vel;
  assign eff_trq = ctrl.live ? trq_reg : run_trq;
  assign eff_acc = ctrl.live ? acc_reg : run_acc;
  assign eff_slope = ctrl.live ? slope_reg : run_slope;
  assign eff_vdir = ctrl.live ? ctrl.vel_dir : run_vdir;
  assign eff_tdir = ctrl.live ? ctrl.trq_dir : run_tdir;
  assign vneg = eff_vdir == axm_pkg::DIR_REV || (eff_vdir == axm_pkg::DIR_KEEP && keep_neg);
  assign tneg = eff_tdir == axm_pkg::DIR_REV;
  assign vtgt = vneg ? -$signed({1'b0, eff_vel}) : $signed({1'b0, eff_vel});
  assign ttgt = tneg ? -$signed({1'b0, eff_trq}) : $signed({1'b0, eff_trq});
  assign at_vel = spd == vtgt;
  assign at_trq = trq == ttgt;

  // ----------------------------------------------------------------
  // Motion profiles
  // ----------------------------------------------------------------
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);
  assign frac_sum = frac + {12'h000, eff_slope};
  // Sub-unit slope kept in a remainder so the rate is exact per second
  assign trq_step = state == axm_pkg::ST_TRQ && frac_sum >= 28'(axm_pkg::CLK_HZ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0000_0000;
      spd <= 16'sh0000;
      dec_now <= axm_pkg::RST_WORD;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (state != axm_pkg::ST_HALT) begin
        dec_now <= axm_pkg::RST_WORD;
      end
      if (state == axm_pkg::ST_IDLE) begin
        spd <= 16'sh0000;
      end else if (tick) begin
        case (state)
          axm_pkg::ST_VEL: spd <= axm_ramp(spd, vtgt, eff_acc);
          axm_pkg::ST_HALT: begin
            spd <= axm_ramp(spd, 16'sh0000, dec_now);
            if (halt_jerk == 16'h0000 || 17'(dec_now) + 17'(halt_jerk) >= 17'(halt_dec)) begin
              dec_now <= halt_dec;
            end else begin
              dec_now <= dec_now + halt_jerk;
            end
          end
          axm_pkg::ST_ESTOP: spd <= axm_ramp(spd, 16'sh0000, ESTOP_STEP);
          default: ; // Torque mode leaves the speed profile alone
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac <= 28'h0000000;
      trq <= 16'sh0000;
    end else if (state != axm_pkg::ST_TRQ) begin
      frac <= 28'h0000000;
      trq <= 16'sh0000;
    end else begin
      frac <= trq_step ? frac_sum - 28'(axm_pkg::CLK_HZ) : frac_sum;
      if (trq_step) begin
        trq <= axm_ramp(trq, ttgt, 16'h0001);
      end
    end
  end

  assign drv_out = '{trq_mode: state == axm_pkg::ST_TRQ, clr_axis: clr_axis,
      clr_common: clr_common, spd_cmd: spd, trq_cmd: trq};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_vel_dir;
    (state == axm_pkg::ST_VEL && eff_vdir == axm_pkg::DIR_REV && eff_vel != 15'h0000)
        |-> vtgt < 16'sh0000;
  endproperty
  a_vel_dir: assert property (p_vel_dir) else $error("reverse velocity target not negative");

  property p_vel_done;
    $rose(done[axm_pkg::CMD_VEL]) |-> $past(spd) == $past(vtgt) && !busy[axm_pkg::CMD_VEL];
  endproperty
  a_vel_done: assert property (p_vel_done) else $error("velocity done before speed reached");

  property p_busy_drop;
    $rose(done[axm_pkg::CMD_TRQ]) |-> !busy[axm_pkg::CMD_TRQ] && $past(trq) == $past(ttgt);
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("torque busy held after done");

  property p_estop_lock;
    (state == axm_pkg::ST_ESTOP && rise == 5'h01) |=> err[axm_pkg::CMD_VEL]
        && errnum == axm_pkg::ERR_ESTOP_LOCK && !act[axm_pkg::CMD_VEL];
  endproperty
  a_estop_lock: assert property (p_estop_lock) else $error("move taken during stop");

  property p_halt_abort;
    (state == axm_pkg::ST_HALT && accept && sel == axm_pkg::CMD_VEL)
        |=> state == axm_pkg::ST_VEL && !act[axm_pkg::CMD_HLT];
  endproperty
  a_halt_abort: assert property (p_halt_abort) else $error("halt not aborted");

  property p_clr_axis;
    (busy[axm_pkg::CMD_CLR] && ctrl.clr_type == axm_pkg::CLR_AXIS && !flt)
        |=> drv_out.clr_axis && !drv_out.clr_common && !axis_err;
  endproperty
  a_clr_axis: assert property (p_clr_axis) else $error("axis clear not issued");

  property p_estop_done;
    $rose(done[axm_pkg::CMD_EST]) |-> $past(spd) == 16'sh0000 && state == axm_pkg::ST_ESTOP;
  endproperty
  a_estop_done: assert property (p_estop_done) else $error("stop done while moving");

  property p_trq_slope;
    (state == axm_pkg::ST_TRQ && !trq_step) |=> trq == $past(trq);
  endproperty
  a_trq_slope: assert property (p_trq_slope) else $error("torque slewed too fast");

  c_vel_done: cover property ($rose(done[axm_pkg::CMD_VEL]));
  c_halt_abort: cover property (state == axm_pkg::ST_HALT ##1 state == axm_pkg::ST_VEL);
  c_clr_done: cover property ($rose(done[axm_pkg::CMD_CLR]));
endmodule
`default_nettype wire

// ==== test/axm_drive_model.sv ====
// Servo drive stand-in: link, servo state, warning, fault-clear pulses.
// Assumes the controller's drive ports on the same pclk.
`timescale 1ns/1ps
`default_nettype none
module axm_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_req,
  input wire logic servo_req,
  input wire logic warn_req,
  input wire axm_pkg::axm_drv_out_t drv_out,
  output axm_pkg::axm_drv_in_t drv_in,
  output int clr_cnt
);
  logic warn;
  // Axis clear counts 1, common clear counts 2, so both are told apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn <= 1'b0;
      clr_cnt <= 0;
    end else if (drv_out.clr_axis || drv_out.clr_common) begin
      warn <= 1'b0;
      clr_cnt <= clr_cnt + int'({drv_out.clr_common, drv_out.clr_axis});
    end else if (warn_req) begin
      warn <= 1'b1;
    end
  end
  // Servo cannot be on without a working link
  assign drv_in = {link_req, servo_req & link_req, warn, warn ? 8'h5A : 8'h00};
endmodule
`default_nettype wire

// ==== test/axis_motion_command_control_bench.sv ====
// Self-checking bench for axm_ctrl over APB with a drive stand-in.
// Assumes the register map and command codes of axm_pkg.
`timescale 1ns/1ps
`default_nettype none
module axis_motion_command_control_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic link_req, servo_req, warn_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tgt, t0;
  axm_pkg::axm_drv_in_t drv_in;
  axm_pkg::axm_drv_out_t drv_out;
  int error_cnt, n_checks, clr_cnt, seed, n;
  axm_ctrl #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drv_in(drv_in), .drv_out(drv_out));
  axm_drive_model drive (.pclk(pclk), .presetn(presetn), .link_req(link_req),
    .servo_req(servo_req), .warn_req(warn_req), .drv_out(drv_out), .drv_in(drv_in),
    .clr_cnt(clr_cnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One idle edge first, so back-to-back calls never drive psel twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_stat(input int b);
    n = 0;
    do begin
      apb(1'b0, axm_pkg::ADDR_STAT, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 3000);
    chk("stat flag", 32'h1, {31'h0, rd[b]});
  endtask
  function automatic logic [15:0] exp_spd(input int d, input logic [15:0] t, input logic [15:0] p);
    return (d == 2 || (d == 3 && p[15])) ? -t : t;
  endfunction
  task end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    seed = 32'h164fa64a;
    {error_cnt, n_checks, presetn, psel, penable, pwrite, warn_req} = '0;
    {paddr, pwdata, link_req, servo_req} = {8'h0, 32'h0, 2'b11};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, axm_pkg::ADDR_CTRL, 32'h0); chk("ctrl reset", axm_pkg::RST_CTRL, rd);
    apb(1'b0, 8'h24, 32'h0); chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, axm_pkg::ADDR_STAT, 32'hFFFF_FFFF); chk("ro write", 32'h1, {31'h0, e});
    apb(1'b0, axm_pkg::ADDR_STAT, 32'h0); chk("idle flags", 32'h7, {28'h0, rd[3:0]});
    for (int d = 0; d < 4; d++) begin
      tgt = 16'(($random(seed) & 32'h3F0) + 16);
      apb(1'b1, axm_pkg::ADDR_VEL, {16'h0, tgt});
      apb(1'b1, axm_pkg::ADDR_ACC, ($random(seed) & 32'hF) + 32'h8);
      apb(1'b0, axm_pkg::ADDR_MON, 32'h0);
      t0 = rd[15:0];
      apb(1'b1, axm_pkg::ADDR_CTRL, 32'(d << 5) | 32'h1);
      if (d == 0) begin
        apb(1'b0, axm_pkg::ADDR_ERR, 32'h0);
        chk("errnum", {24'h0, axm_pkg::ERR_BAD_DIR}, {24'h0, rd[15:8]});
        chk("err bit", 32'h1, {31'h0, rd[0]});
        apb(1'b0, axm_pkg::ADDR_STAT, 32'h0); chk("err flag", 32'h1, {31'h0, rd[2]});
        for (int c = 0; c < 2; c++) begin
          apb(1'b1, axm_pkg::ADDR_CTRL, 32'h10 | 32'(c << 11));
          wait_stat(28);
          chk("clear pulses", 32'(1 + 2 * c), 32'(clr_cnt));
          apb(1'b1, axm_pkg::ADDR_CTRL, 32'h0);
        end
        apb(1'b0, axm_pkg::ADDR_STAT, 32'h0); chk("latches", 32'h0, {30'h0, rd[5:4]});
      end else begin
        wait_stat(24);
        chk("busy act op", 32'h0001_0008, rd & 32'h000F_1F08);
        apb(1'b0, axm_pkg::ADDR_MON, 32'h0);
        chk("speed", {16'h0, exp_spd(d, tgt, t0)}, {16'h0, rd[15:0]});
      end
      apb(1'b1, axm_pkg::ADDR_CTRL, 32'h0);
    end
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h8);
    wait_stat(27);
    apb(1'b0, axm_pkg::ADDR_MON, 32'h0); chk("estop speed", 32'h0, {16'h0, rd[15:0]});
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h29);
    apb(1'b0, axm_pkg::ADDR_ERR, 32'h0); chk("lock errnum", 32'h1, {24'h0, rd[15:8]});
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, axm_pkg::ADDR_ACC, 32'h2);
    apb(1'b1, axm_pkg::ADDR_HALT, 32'h0001_0004);
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h21);
    // Halt queued behind the ramping move
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h225);
    apb(1'b0, axm_pkg::ADDR_STAT, 32'h0);
    chk("queued", 32'h0001_0500, rd & 32'h0005_0500);
    wait_stat(26);
    chk("queued halt idle", 32'h0, {31'h0, rd[3]});
    chk("move done first", 32'h1, {31'h0, rd[24]});
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h20);
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h21);
    wait_stat(24);
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h4);
    apb(1'b0, axm_pkg::ADDR_STAT, 32'h0);
    chk("halting", 32'h4, {28'h0, rd[19:16]});
    // Move takes over from the halt, target followed live
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h425);
    wait_stat(24);
    chk("abort act", 32'h1, {28'h0, rd[19:16]});
    tgt = tgt + 16'h20;
    apb(1'b1, axm_pkg::ADDR_VEL, {16'h0, tgt});
    repeat (100) @(posedge pclk);
    apb(1'b0, axm_pkg::ADDR_MON, 32'h0);
    chk("live speed", {16'h0, tgt}, {16'h0, rd[15:0]});
    apb(1'b1, axm_pkg::ADDR_TRQ, 32'h100);
    apb(1'b1, axm_pkg::ADDR_SLOPE, 32'hFFFF);
    for (int d = 1; d < 3; d++) begin
      t0 = drv_out.trq_cmd;
      apb(1'b1, axm_pkg::ADDR_CTRL, 32'(d << 7) | 32'h2);
      n = 0;
      while (drv_out.trq_cmd === t0 && n < 20000) begin
        @(negedge pclk);
        n++;
      end
      chk("torque step", {16'h0, d == 1 ? t0 + 16'h1 : t0 - 16'h1}, {16'h0, drv_out.trq_cmd});
      chk("torque mode", 32'h1, {31'h0, drv_out.trq_mode});
      if (d == 1) chk("slope wait", 32'h1, {31'h0, n >= 3800});
      apb(1'b1, axm_pkg::ADDR_CTRL, 32'h0);
    end
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h4);
    wait_stat(26);
    chk("halt idle", 32'h0, {31'h0, rd[3]});
    apb(1'b1, axm_pkg::ADDR_CTRL, 32'h0);
    warn_req <= 1'b1;
    apb(1'b0, axm_pkg::ADDR_STAT, 32'h0); chk("warn flag", 32'h1, {31'h0, rd[2]});
    warn_req <= 1'b0;
    servo_req <= 1'b0;
    apb(1'b0, axm_pkg::ADDR_STAT, 32'h0); chk("servo off", 32'h1, {30'h0, rd[1:0]});
    link_req <= 1'b0;
    apb(1'b0, axm_pkg::ADDR_STAT, 32'h0); chk("link lost", 32'h0, {31'h0, rd[0]});
    end_sim();
  end
endmodule
`default_nettype wire
